/* design/gpb_port.v */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// What this block does
// (RULE1) eight pins, one direction bit each
// (RULE2) direction one: driver off, pin input
// (RULE3) direction zero: drive output latch value
// (RULE4) pull-up needs own bit and global low
// (RULE5) output pins never get pull-up
// (RULE6) pull-ups off after power-on reset
// (RULE7) pull-up enables at 95h, reset ones
// (RULE8) change selects at 96h, reset F0
// (RULE9) detect only selected input pins
// (RULE10) compare against snapshot from last port read or write
// (RULE11) OR mismatches into change flag bit0
// (RULE12) change event wakes device from sleep
// (RULE13) port access refreshes comparison snapshot
// (RULE14) mismatch keeps setting flag over clear
// (RULE15) irq needs global and change enables
// (RULE16) change enable gates whole detection feature
// (RULE17) software avoids polling during change detection
// (RULE18) pin 0 doubles as analog four, ext irq
// (RULE19) pin 1 doubles as analog five, select
// (RULE20) reset makes pins 0,1 analog, read zero
// (RULE21) port at 06h and 106h, low bits zero
// (RULE22) timer1 oscillator overrides pin 6
// (RULE23) read returns pins, write sets latch
// (RULE24) analog select kills digital input, pull-up
// (RULE25) direction resets to all inputs
`include "gpb_consts.vh"

module gpb_port #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             clk,
	input  wire             srst,
	input  wire             por,
	// register port
	input  wire [8:0]       reg_addr,
	input  wire [7:0]       reg_wdata,
	input  wire             reg_wr,
	input  wire             reg_rd,
	output reg  [7:0]       reg_rdata,
	// pins
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_out,
	output reg  [WIDTH-1:0] pin_oe,
	output reg  [WIDTH-1:0] pin_pullup,
	// shared pin functions
	output reg              ext_irq_in,
	output reg              slave_select_in,
	output reg              analog_in_four_sel,
	output reg              analog_in_five_sel,
	output reg              timer1_osc_enable,
	// interrupt and wake
	output reg              change_irq,
	output reg              wake_req
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg  [7:0]       option_config_reg;
reg  [WIDTH-1:0] pin_direction_reg;
reg  [WIDTH-1:0] pull_up_enables_reg;
reg  [WIDTH-1:0] change_irq_select_reg;
reg  [7:0]       analog_select_reg;
reg  [7:0]       irq_control_reg;
reg  [7:0]       misc_reg;
reg  [WIDTH-1:0] out_latch_reg;
reg  [WIDTH-1:0] snapshot_reg;
wire [WIDTH-1:0] pin_sync;
reg  [WIDTH-1:0] pin_digital;
reg  [WIDTH-1:0] mismatch;
reg  [WIDTH-1:0] pull_next;
reg  [WIDTH-1:0] oe_next;
reg  [7:0]       rdata_next;
reg              change_any;
reg              pull_global_on;

function is_addr;
	input [8:0] a;
	input [8:0] prim;
	input [8:0] alt;
	begin
		is_addr = (a == prim) || (a == alt);
	end
endfunction

// pins whose digital view is removed by analog select
function [WIDTH-1:0] analog_mask;
	input [7:0] ans;
	begin
		analog_mask    = {WIDTH{1'b0}};
		analog_mask[0] = ans[`GPB_ANS_PIN0];
		analog_mask[1] = ans[`GPB_ANS_PIN1];
	end
endfunction

wire port_hit = is_addr(reg_addr, `GPB_ADDR_PORT, `GPB_ADDR_PORT_ALT);
wire opt_hit  = is_addr(reg_addr, `GPB_ADDR_OPTION, `GPB_ADDR_OPTION_ALT);
wire dir_hit  = is_addr(reg_addr, `GPB_ADDR_DIR, `GPB_ADDR_DIR_ALT);
wire pu_hit   = is_addr(reg_addr, `GPB_ADDR_PULLUP, `GPB_ADDR_PULLUP);
wire ioc_hit  = is_addr(reg_addr, `GPB_ADDR_IOC_SEL, `GPB_ADDR_IOC_SEL);
wire ans_hit  = is_addr(reg_addr, `GPB_ADDR_ANALOG_SELECT, `GPB_ADDR_ANALOG_SELECT);
wire irq_hit  = is_addr(reg_addr, `GPB_ADDR_IRQ_CTRL, `GPB_ADDR_IRQ_CTRL);
wire misc_hit = is_addr(reg_addr, `GPB_ADDR_MISC, `GPB_ADDR_MISC);

////////////////////////////////////////////////////////////////////////////////
// write strobes per register, read strobe for the port only
wire wr_port  = reg_wr && port_hit;
wire rd_port  = reg_rd && port_hit;
wire wr_opt   = reg_wr && opt_hit;
wire wr_dir   = reg_wr && dir_hit;
wire wr_pu    = reg_wr && pu_hit;
wire wr_ioc   = reg_wr && ioc_hit;
wire wr_ans   = reg_wr && ans_hit;
wire wr_irq   = reg_wr && irq_hit;
wire wr_misc  = reg_wr && misc_hit;

////////////////////////////////////////////////////////////////////////////////
// interrupt control fields
wire change_en   = irq_control_reg[`GPB_IRQ_CHANGE_EN];
wire change_flag = irq_control_reg[`GPB_IRQ_CHANGE_FLAG];
wire global_en   = irq_control_reg[`GPB_IRQ_GLOBAL_EN];

////////////////////////////////////////////////////////////////////////////////
// pin input path

gpb_sync3 #(
	.WIDTH (WIDTH)
) u_sync (
	.clk  (clk),
	.srst (srst),
	.din  (pin_in),
	.dout (pin_sync)
);

always @* begin
	// (RULE24) analog pins read zero
	// (RULE20) reset leaves pins 0,1 reading zero
	pin_digital = pin_sync & ~analog_mask(analog_select_reg);
end

////////////////////////////////////////////////////////////////////////////////
// change detection

always @* begin
	// (RULE9) selected inputs only
	// (RULE10) compare against snapshot
	// (RULE16) feature gated by enable
	mismatch = (pin_digital ^ snapshot_reg) & change_irq_select_reg
		& pin_direction_reg & {WIDTH{irq_control_reg[`GPB_IRQ_CHANGE_EN]}};
	// (RULE11) OR of all mismatches
	change_any = |mismatch;
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers

always @(posedge clk) begin
	if (srst) begin
		// (RULE25) all pins start as inputs
		pin_direction_reg     <= `GPB_RST_DIR;
		// (RULE6) global pull-up off at reset
		option_config_reg     <= `GPB_RST_OPTION;
		// (RULE7) enables reset to ones
		pull_up_enables_reg   <= `GPB_RST_PULLUP;
		// (RULE8) upper four selected
		change_irq_select_reg <= `GPB_RST_IOC_SEL;
		// (RULE20) pins 0,1 analog after reset
		analog_select_reg     <= `GPB_RST_ANALOG_SELECT;
		misc_reg              <= `GPB_RST_MISC;
	end else begin
		if (wr_opt)
			option_config_reg <= reg_wdata;
		if (wr_dir)
			pin_direction_reg <= reg_wdata[WIDTH-1:0];
		if (wr_pu)
			pull_up_enables_reg <= reg_wdata[WIDTH-1:0];
		if (wr_ioc)
			change_irq_select_reg <= reg_wdata[WIDTH-1:0];
		if (wr_ans)
			analog_select_reg <= reg_wdata;
		if (wr_misc)
			misc_reg <= reg_wdata;
	end
end

////////////////////////////////////////////////////////////////////////////////
// output data latch

always @(posedge clk) begin
	if (srst) begin
		// (RULE21) latch kept except on power-on
		if (por)
			out_latch_reg <= {WIDTH{1'b0}};
	end else if (wr_port) begin
		// (RULE23) write only updates latch
		out_latch_reg <= reg_wdata[WIDTH-1:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// comparison snapshot

always @(posedge clk) begin
	if (srst) begin
		snapshot_reg <= {WIDTH{1'b0}};
	end else if (wr_port || rd_port) begin
		// (RULE13) any port access refreshes snapshot
		// (RULE10) snapshot feeds the comparison
		snapshot_reg <= pin_digital;
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt control

always @(posedge clk) begin
	if (srst) begin
		irq_control_reg <= `GPB_RST_IRQ_CTRL;
	end else begin
		if (wr_irq)
			irq_control_reg <= reg_wdata;
		// (RULE14) mismatch sets flag, wins over clear
		if (change_any)
			irq_control_reg[`GPB_IRQ_CHANGE_FLAG] <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive and pull-ups

always @* begin
	// (RULE1) one direction bit per pin
	// (RULE2) direction one releases driver
	// (RULE3) direction zero drives latch
	oe_next = ~pin_direction_reg;
	// (RULE22) timer1 oscillator takes pin 6
	if (misc_reg[`GPB_MISC_T1OSC_EN])
		oe_next[6] = 1'b0;
end

always @* begin
	pull_global_on = ~option_config_reg[`GPB_OPT_PULLUP_OFF_N];
	// (RULE4) own bit plus global enable
	// (RULE5) no pull-up on outputs
	pull_next = pull_up_enables_reg & pin_direction_reg & {WIDTH{pull_global_on}};
	// (RULE24) analog pins lose pull-up
	if (analog_select_reg[`GPB_ANS_PIN0])
		pull_next[0] = 1'b0;
	if (analog_select_reg[`GPB_ANS_PIN1])
		pull_next[1] = 1'b0;
	if (misc_reg[`GPB_MISC_T1OSC_EN])
		pull_next[6] = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// read mux

always @* begin
	rdata_next = 8'h00;
	if (port_hit)
		// (RULE23) read returns pin states
		rdata_next = pin_digital;
	else if (opt_hit)
		rdata_next = option_config_reg;
	else if (dir_hit)
		rdata_next = pin_direction_reg;
	else if (pu_hit)
		rdata_next = pull_up_enables_reg;
	else if (ioc_hit)
		rdata_next = change_irq_select_reg;
	else if (ans_hit)
		rdata_next = analog_select_reg;
	else if (irq_hit)
		rdata_next = irq_control_reg;
	else if (misc_hit)
		rdata_next = misc_reg;
end

////////////////////////////////////////////////////////////////////////////////
// register read data

always @(posedge clk) begin
	if (srst) begin
		reg_rdata <= 8'h00;
	end else begin
		// (RULE23) data stands one cycle only
		reg_rdata <= reg_rd ? rdata_next : 8'h00;
	end
end

////////////////////////////////////////////////////////////////////////////////
// pin outputs

always @(posedge clk) begin
	if (srst) begin
		pin_out    <= {WIDTH{1'b0}};
		pin_oe     <= {WIDTH{1'b0}};
		pin_pullup <= {WIDTH{1'b0}};
	end else begin
		pin_out    <= out_latch_reg & oe_next;
		pin_oe     <= oe_next;
		pin_pullup <= pull_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// shared pin functions

always @(posedge clk) begin
	if (srst) begin
		ext_irq_in         <= 1'b0;
		slave_select_in    <= 1'b0;
		analog_in_four_sel <= 1'b1;
		analog_in_five_sel <= 1'b1;
		timer1_osc_enable  <= 1'b0;
	end else begin
		// (RULE18) pin 0 analog four and ext irq
		analog_in_four_sel <= analog_select_reg[`GPB_ANS_PIN0];
		ext_irq_in         <= pin_digital[0];
		// (RULE19) pin 1 analog five and select
		analog_in_five_sel <= analog_select_reg[`GPB_ANS_PIN1];
		slave_select_in    <= pin_digital[1];
		timer1_osc_enable  <= misc_reg[`GPB_MISC_T1OSC_EN];
	end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt and wake outputs

always @(posedge clk) begin
	if (srst) begin
		change_irq <= 1'b0;
		wake_req   <= 1'b0;
	end else begin
		// (RULE15) both enables gate the irq
		change_irq <= global_en & change_en & change_flag;
		// (RULE12) flag wakes from sleep
		wake_req   <= change_en & change_flag;
	end
end

endmodule

/* common/gpb_consts.vh */
`ifndef GPB_CONSTS_VH
`define GPB_CONSTS_VH

// register addresses (9-bit space)
`define GPB_ADDR_PORT       9'h006
`define GPB_ADDR_PORT_ALT   9'h106
`define GPB_ADDR_OPTION     9'h081
`define GPB_ADDR_OPTION_ALT 9'h181
`define GPB_ADDR_DIR        9'h086
`define GPB_ADDR_DIR_ALT    9'h186
`define GPB_ADDR_PULLUP     9'h095
`define GPB_ADDR_IOC_SEL    9'h096
`define GPB_ADDR_ANALOG_SELECT      9'h09D
`define GPB_ADDR_IRQ_CTRL   9'h00B
`define GPB_ADDR_MISC       9'h0A0

// reset values
`define GPB_RST_OPTION      8'hFF
`define GPB_RST_DIR         8'hFF
`define GPB_RST_PULLUP      8'hFF
`define GPB_RST_IOC_SEL     8'hF0
`define GPB_RST_ANALOG_SELECT       8'hFF
`define GPB_RST_IRQ_CTRL    8'h00
`define GPB_RST_MISC        8'h00

// field positions
`define GPB_OPT_PULLUP_OFF_N 7
`define GPB_IRQ_GLOBAL_EN    7
`define GPB_IRQ_CHANGE_EN    3
`define GPB_IRQ_CHANGE_FLAG  0
`define GPB_MISC_T1OSC_EN    0
`define GPB_ANS_PIN0         4
`define GPB_ANS_PIN1         5

`endif

/* design/gpb_sync3.v */
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module gpb_sync3 #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             clk,
	input  wire             srst,
	// data
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);

reg [WIDTH-1:0] s1_reg;
reg [WIDTH-1:0] s2_reg;
reg [WIDTH-1:0] s3_reg;
integer i;

always @(posedge clk) begin
	if (srst) begin
		s1_reg <= {WIDTH{1'b0}};
		s2_reg <= {WIDTH{1'b0}};
		s3_reg <= {WIDTH{1'b0}};
		dout   <= {WIDTH{1'b0}};
	end else begin
		s1_reg <= din;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		for (i = 0; i < WIDTH; i = i + 1) begin
			if (s2_reg[i] == s3_reg[i]) begin
				dout[i] <= s3_reg[i];
			end
		end
	end
end

endmodule

/* testbench/gpb_port_chk.sv */
`timescale 1ns/1ps
module gpb_port_chk (
	// clock and reset
	input wire       clk,
	input wire       srst,
	// register port
	input wire [8:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	// pins and shared functions
	input wire [7:0] pin_out,
	input wire [7:0] pin_oe,
	input wire [7:0] pin_pullup,
	input wire       ext_irq_in,
	input wire       slave_select_in,
	input wire       analog_in_four_sel,
	input wire       analog_in_five_sel,
	input wire       timer1_osc_enable,
	input wire       change_irq,
	input wire       wake_req
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_dir_to_oe: assert property (reg_wr && reg_addr == 9'h086 && !timer1_osc_enable ##1 !reg_wr
		|-> ##1 pin_oe == ~$past(reg_wdata, 2)) else $error("drive enable off");
	a_out_needs_oe: assert property ((pin_out & ~pin_oe) == 8'h00) else $error("undriven out");
	a_no_pull_out: assert property ((pin_pullup & pin_oe) == 8'h00) else $error("pull on out");
	a_irq_gated: assert property (change_irq |-> wake_req) else $error("irq without enable");
	a_analog_dig: assert property ((!analog_in_four_sel || !ext_irq_in)
		&& (!analog_in_five_sel || !slave_select_in)) else $error("analog pin digital");
	a_reset_state: assert property ($fell(srst) |-> pin_pullup == 8'h00
		&& pin_oe == 8'h00 && analog_in_four_sel && analog_in_five_sel) else $error("reset state");
	a_osc_pin6: assert property (timer1_osc_enable |-> !pin_oe[6] && !pin_pullup[6])
		else $error("pin6 not released");
	a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray data");
	a_port_low_zero: assert property (reg_rd && reg_addr == 9'h006 && analog_in_four_sel
		&& analog_in_five_sel |=> reg_rdata[1:0] == 2'h0) else $error("analog bits read");
endmodule
bind gpb_port gpb_port_chk chk_u (.*);

/* testbench/gpb_pins_model.sv */
`timescale 1ns/1ps
module gpb_pins_model (
	// clock
	input  wire        clk,
	// device side
	input  wire  [7:0] pin_out,
	input  wire  [7:0] pin_oe,
	input  wire  [7:0] pin_pullup,
	// keys
	input  wire  [7:0] key_en,
	input  wire  [7:0] key_val,
	output logic [7:0] pin_in
);
	logic [7:0] flt = 8'h00;
	// floating pins show the inverse of the last level
	always @(posedge clk) begin
		flt <= ~pin_in;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & key_en & key_val)
		| (~pin_oe & ~key_en & (pin_pullup | flt));
endmodule

/* testbench/gpb_port_tb.sv */
`timescale 1ns/1ps
module gpb_port_tb;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       por = 1'b1;
	logic [8:0] reg_addr = 9'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] key_en = 8'hFF;
	logic [7:0] key_val = 8'hA5;
	wire  [7:0] pin_in, pin_out, pin_oe, pin_pu, rdata;
	wire        ext_irq, ss_in, an4, an5, t1, change_irq, wake_req;
	int         miscompares = 0;
	int         n_tests = 0;
	int         cyc = 0;
	gpb_port dut_u (.clk(clk), .srst(srst), .por(por), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
		.ext_irq_in(ext_irq), .slave_select_in(ss_in), .analog_in_four_sel(an4),
		.analog_in_five_sel(an5), .timer1_osc_enable(t1), .change_irq(change_irq),
		.wake_req(wake_req));
	gpb_pins_model pins_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pu), .key_en(key_en), .key_val(key_val), .pin_in(pin_in));
	initial forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////
	task complete_run;
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input [7:0] s, input [7:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task wr(input [8:0] a, input [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [8:0] a, input [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			complete_run;
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		rd(9'h081, 8'hFF);
		rd(9'h086, 8'hFF);
		rd(9'h095, 8'hFF);
		rd(9'h096, 8'hF0);
		rd(9'h09D, 8'hFF);
		rd(9'h1FF, 8'h00);
		rd(9'h006, 8'hA4);
		rd(9'h106, 8'hA4);
		chk(pin_pu, 8'h00);
		chk({an5, an4}, 8'h03);
		wr(9'h09D, 8'h00);
		wr(9'h081, 8'h7F);
		key_en <= 8'h0F;
		w(6);
		chk(pin_pu, 8'hFF);
		rd(9'h006, 8'hF5);
		chk(ext_irq, 8'h01);
		chk(ss_in, 8'h00);
		wr(9'h086, 8'h0F);
		wr(9'h006, 8'h3C);
		w(2);
		chk(pin_oe, 8'hF0);
		chk(pin_out, 8'h30);
		chk(pin_pu, 8'h0F);
		w(4);
		rd(9'h006, 8'h35);
		wr(9'h081, 8'hFF);
		w(2);
		chk(pin_pu, 8'h00);
		wr(9'h086, 8'hFF);
		key_en <= 8'hFF;
		wr(9'h00B, 8'h88);
		w(5);
		rd(9'h006, 8'hA5);
		wr(9'h00B, 8'h88);
		key_val <= 8'hA4;
		w(6);
		chk(change_irq, 8'h00);
		// no port polling while change armed
		@(posedge clk);
		key_val <= 8'h24;
		w(6);
		chk(change_irq, 8'h01);
		chk(wake_req, 8'h01);
		wr(9'h00B, 8'h88);
		rd(9'h00B, 8'h89);
		rd(9'h006, 8'h24);
		wr(9'h00B, 8'h88);
		rd(9'h00B, 8'h88);
		chk(change_irq, 8'h00);
		wr(9'h00B, 8'h80);
		key_val <= 8'hA4;
		w(6);
		chk(wake_req, 8'h00);
		rd(9'h00B, 8'h80);
		wr(9'h00B, 8'h08);
		w(3);
		chk(wake_req, 8'h01);
		chk(change_irq, 8'h00);
		wr(9'h0A0, 8'h01);
		wr(9'h086, 8'h00);
		w(2);
		chk(pin_oe, 8'hBF);
		chk(t1, 8'h01);
		@(posedge clk);
		srst <= 1'b1;
		por <= 1'b0;
		w(2);
		@(posedge clk);
		srst <= 1'b0;
		wr(9'h086, 8'h00);
		wr(9'h09D, 8'h00);
		w(2);
		chk(pin_out, 8'h3C);
		complete_run;
	end
endmodule
